// ===== core/sdct_pkg.sv
// Purpose: Shared constants and types for the SDRAM command timing core.
// Assumes: One 100 MHz clock; commands are coded as {cs_n, ras_n, cas_n, we_n}.
// Notes:   Long counts derive from times in their own units.
package sdct_pkg;
    localparam int CLK_NS     = 10;
    localparam int INIT_US    = 100;
    localparam int INIT_CYC   = (INIT_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int REF_MS     = 64;
    localparam int REF_AT_MS  = 16;
    localparam int REF_CYC    = REF_MS * 1000000 / CLK_NS;
    localparam int REF_AT_CYC = REF_AT_MS * 1000000 / CLK_NS;
    localparam int DW         = 8;
    localparam int COLW       = 3;
    localparam int AW         = 12;
    localparam int CNTW       = 23;
    localparam int ROWW       = 13;
    localparam int RL_MAX     = 3;
    localparam int AP_BIT     = 10;
    localparam int MR_BL      = 0;
    localparam int MR_RL      = 4;
    localparam int ST_INIT    = 0;
    localparam int ST_EXP     = 1;
    localparam int ST_PDN     = 2;
    localparam int ST_SREF    = 3;
    localparam int ST_OPEN    = 4;
    localparam int ST_RL      = 8;
    localparam int MEMN       = 4 << COLW;
    localparam logic [ROWW-1:0] ROWS      = 13'h1000;
    localparam logic [1:0]      WAKE_LAST = 2'h1;
    localparam logic [3:0]      CMD_ACT   = 4'h3;
    localparam logic [3:0]      CMD_RD    = 4'h5;
    localparam logic [3:0]      CMD_WR    = 4'h4;
    localparam logic [3:0]      CMD_BST   = 4'h6;
    localparam logic [3:0]      CMD_PRE   = 4'h2;
    localparam logic [3:0]      CMD_REF   = 4'h1;
    localparam logic [3:0]      CMD_LMR   = 4'h0;
    localparam logic [3:0]      REG_CFG   = 4'h0;
    localparam logic [3:0]      REG_STAT  = 4'h4;
    localparam logic [3:0]      REG_MODE  = 4'h8;
    localparam logic [AW-1:0]   MODE_RST  = 12'h030;

    typedef enum logic [2:0] {PM_RUN = 3'b001, PM_PDN = 3'b010, PM_SREF = 3'b100} sdct_pm_e;

    typedef struct packed {
        logic cs_n; logic ras_n; logic cas_n; logic we_n; logic cke; logic dqm;
        logic [1:0] ba; logic [AW-1:0] addr; logic [DW-1:0] dq;
    } sdct_pin_s;

    typedef struct packed {logic v; logic [DW-1:0] data;} sdct_rd_s;

    typedef struct packed {
        sdct_pin_s p1; sdct_pin_s p2; logic cke_q; logic dqm_q; sdct_pm_e pm;
        logic [AW-1:0] mode; logic [3:0] open; logic b_wr; logic b_ap; logic [1:0] b_ba;
        logic [COLW-1:0] b_col; logic [2:0] b_left; sdct_rd_s [RL_MAX-1:0] pipe;
        logic [MEMN-1:0][DW-1:0] mem; logic [CNTW-1:0] init_cnt; logic init_wait;
        logic [1:0] wake; logic init_done; logic [CNTW-1:0] win_cnt; logic [ROWW-1:0] ref_cnt;
        logic expired; logic cfg_at; logic [31:0] rdata;
    } sdct_st_s;

    localparam sdct_st_s ST_RST = '{pm: PM_RUN, mode: MODE_RST, default: '0};
endpackage

// ===== core/sdct_core.sv
// Purpose: Device side of a quad-bank SDRAM: command decode, bursts, masks, power modes.
// Assumes: Controller pins arrive on mclk_i; a small flip-flop array stands in for the cells.
// Notes:   Every input pin passes two flops, so latencies between inputs hold but read data reach dq_o two clocks late.
`timescale 1ns/100ps
// Overview of operation
// - A new READ or WRITE is accepted on every clock.
// - Clock-enable sampled low suspends or powers down one clock later.
// - Clock-enable sampled high resumes or leaves power-down one clock later.
// - Write mask applies to the data word sampled on the same clock.
// - Read mask high turns data outputs off two clocks later.
// - First write data word is sampled with the WRITE command itself.
// - PRECHARGE during a read turns outputs off after read_latency_setting clocks.
// - All command, address, mask and data inputs register on the rising edge.
// - Address bit 10 on READ or WRITE selects precharge after the burst.
module sdct_core
    import sdct_pkg::*;
#(
    parameter int INIT_CYC_P   = INIT_CYC,
    parameter int REF_CYC_P    = REF_CYC,
    parameter int REF_AT_CYC_P = REF_AT_CYC
)(
    input  wire logic          mclk_i,
    input  wire logic          arst_n_i,
    input  wire logic          cs_n_i,
    input  wire logic          ras_n_i,
    input  wire logic          cas_n_i,
    input  wire logic          we_n_i,
    input  wire logic          cke_i,
    input  wire logic          dqm_i,
    input  wire logic [1:0]    ba_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] dq_i,
    output logic      [DW-1:0] dq_o,
    output logic               dq_oe_o,
    input  wire logic [3:0]    reg_addr_i,
    input  wire logic [31:0]   reg_wdata_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    output logic      [31:0]   reg_rdata_o
);
    localparam logic [CNTW-1:0] INIT_LAST = CNTW'(INIT_CYC_P - 1);
    localparam logic [CNTW-1:0] WIN_LAST  = CNTW'(REF_CYC_P - 1);
    localparam logic [CNTW-1:0] WIN_AT    = CNTW'(REF_AT_CYC_P - 1);

    sdct_st_s        s_q;
    sdct_st_s        d;
    sdct_pin_s       p;
    logic [3:0]      cmd;
    logic            en;
    logic            col_cmd;
    logic            pre_hit;
    logic            stop;
    logic            acc_go;
    logic            acc_wr;
    logic            ap_now;
    logic [2:0]      bl_m1;
    logic [2:0]      left_nxt;
    logic [2:0]      rl;
    logic [1:0]      rl_ix;
    logic [1:0]      acc_ba;
    logic [COLW-1:0] acc_col;
    logic [COLW-1:0] nxt_col;
    logic [COLW+1:0] acc_idx;
    logic [DW-1:0]   cur_word;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    assign p        = s_q.p2;
    assign cmd      = {p.cs_n, p.ras_n, p.cas_n, p.we_n};
    // Commands count only if clock-enable was high at the previous edge.
    assign en       = s_q.cke_q && (s_q.pm == PM_RUN);
    assign col_cmd  = (cmd == CMD_RD) || (cmd == CMD_WR);
    assign pre_hit  = (cmd == CMD_PRE) && (p.addr[AP_BIT] || (p.ba == s_q.b_ba));
    assign stop     = (cmd == CMD_BST) || pre_hit;
    assign rl       = s_q.mode[MR_RL +: 3];
    assign rl_ix    = (rl == 3'h1) ? 2'h0 : ((rl == 3'h2) ? 2'h1 : 2'h2);
    assign bl_m1    = (s_q.mode[MR_BL +: 3] == 3'h1) ? 3'h1 :
                      (s_q.mode[MR_BL +: 3] == 3'h2) ? 3'h3 :
                      (s_q.mode[MR_BL +: 3] == 3'h3) ? 3'h7 : 3'h0;
    assign nxt_col  = (s_q.b_col & ~bl_m1) | (COLW'(s_q.b_col + 1'b1) & bl_m1);
    assign acc_ba   = col_cmd ? p.ba : s_q.b_ba;
    assign acc_col  = col_cmd ? p.addr[COLW-1:0] : nxt_col;
    assign acc_idx  = {acc_ba, acc_col};
    assign acc_wr   = col_cmd ? (cmd == CMD_WR) : s_q.b_wr;
    assign ap_now   = col_cmd ? p.addr[AP_BIT] : s_q.b_ap;
    assign left_nxt = col_cmd ? bl_m1 : 3'(s_q.b_left - 1'b1);
    assign acc_go   = en && (col_cmd || ((s_q.b_left != 3'h0) && !stop));
    assign cur_word = s_q.mem[acc_idx];

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        d = s_q;
        d.p1    = '{cs_n_i, ras_n_i, cas_n_i, we_n_i, cke_i, dqm_i, ba_i, addr_i, dq_i};
        d.p2    = s_q.p1;
        d.cke_q = p.cke;
        d.rdata = '0;
        if (en)
        begin
            d.dqm_q = p.dqm;
            for (int i = 0; i < RL_MAX - 1; i++)
            begin
                d.pipe[i] = s_q.pipe[i+1];
            end
            d.pipe[RL_MAX-1] = '0;
            if (stop)
            begin
                d.b_left = '0;
            end
            if (acc_go)
            begin
                d.b_col  = acc_col;
                d.b_ba   = acc_ba;
                d.b_wr   = acc_wr;
                d.b_ap   = ap_now;
                d.b_left = left_nxt;
                if (acc_wr && !p.dqm)
                begin
                    d.mem[acc_idx] = p.dq;
                end
                else if (!acc_wr)
                begin
                    d.pipe[rl_ix] = '{1'b1, cur_word};
                end
                if ((left_nxt == 3'h0) && ap_now)
                begin
                    d.open[acc_ba] = 1'b0;
                end
            end
            if (s_q.dqm_q)
            begin
                d.pipe[0].v = 1'b0;
            end
            if (cmd == CMD_ACT)
            begin
                d.open[p.ba] = 1'b1;
            end
            if (cmd == CMD_PRE)
            begin
                if (p.addr[AP_BIT])
                begin
                    d.open = '0;
                end
                else
                begin
                    d.open[p.ba] = 1'b0;
                end
            end
            if (cmd == CMD_LMR)
            begin
                d.mode = p.addr;
            end
            if ((cmd == CMD_REF) && p.cke)
            begin
                if (s_q.ref_cnt != ROWS)
                begin
                    d.ref_cnt = ROWW'(s_q.ref_cnt + 1'b1);
                end
                if (s_q.init_wait && !s_q.init_done)
                begin
                    d.wake      = 2'(s_q.wake + 1'b1);
                    d.init_done = (s_q.wake == WAKE_LAST);
                end
            end
        end

        case (s_q.pm)
            PM_RUN:
            begin
                if (s_q.cke_q && !p.cke)
                begin
                    if (cmd == CMD_REF)
                    begin
                        d.pm = PM_SREF;
                    end
                    else if (s_q.b_left == 3'h0)
                    begin
                        d.pm = PM_PDN;
                    end
                end
            end
            PM_PDN, PM_SREF:
            begin
                if (p.cke)
                begin
                    d.pm = PM_RUN;
                end
            end
            default:
            begin
                d.pm = PM_RUN;
            end
        endcase

        if (!s_q.init_wait)
        begin
            d.init_cnt  = CNTW'(s_q.init_cnt + 1'b1);
            d.init_wait = (s_q.init_cnt == INIT_LAST);
        end

        if (reg_wr_i && (reg_addr_i == REG_CFG))
        begin
            d.cfg_at = reg_wdata_i[0];
        end
        if (reg_wr_i && (reg_addr_i == REG_STAT) && reg_wdata_i[ST_EXP])
        begin
            d.expired = 1'b0;
        end

        if (s_q.pm == PM_SREF)
        begin
            d.ref_cnt = ROWS;
        end
        d.win_cnt = CNTW'(s_q.win_cnt + 1'b1);
        if (s_q.win_cnt == (s_q.cfg_at ? WIN_AT : WIN_LAST))
        begin
            d.win_cnt = '0;
            d.ref_cnt = '0;
            if (s_q.init_done && (d.ref_cnt != ROWS) && (s_q.pm != PM_SREF) && (s_q.ref_cnt != ROWS))
            begin
                d.expired   = 1'b1;
                d.init_done = 1'b0;
                d.wake      = '0;
            end
        end

        if (reg_rd_i)
        begin
            case (reg_addr_i)
                REG_CFG:  d.rdata[0] = s_q.cfg_at;
                REG_STAT:
                begin
                    d.rdata[ST_INIT]      = s_q.init_done;
                    d.rdata[ST_EXP]       = s_q.expired;
                    d.rdata[ST_PDN]       = (s_q.pm == PM_PDN);
                    d.rdata[ST_SREF]      = (s_q.pm == PM_SREF);
                    d.rdata[ST_OPEN +: 4] = s_q.open;
                    d.rdata[ST_RL +: 3]   = rl;
                end
                REG_MODE: d.rdata[AW-1:0] = s_q.mode;
                default:  d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_q <= ST_RST;
        end
        else
        begin
            s_q <= d;
        end
    end

    assign dq_o        = s_q.pipe[0].data;
    assign dq_oe_o     = s_q.pipe[0].v;
    assign reg_rdata_o = s_q.rdata;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    col_every_a: assert property (en && col_cmd |=> s_q.b_col == $past(s_q.p2.addr[COLW-1:0]))
        else $error("column command not taken");
    cke_susp_a: assert property (en && !p.cke && (cmd != CMD_REF) |=> ##1 $stable(s_q.pipe))
        else $error("clock suspend late");
    cke_resume_a: assert property (s_q.pm == PM_PDN && p.cke |=> s_q.pm == PM_RUN && s_q.cke_q)
        else $error("power-down exit late");
    wr_mask_a: assert property (acc_go && acc_wr && p.dqm |=> s_q.mem[$past(acc_idx)] == $past(cur_word))
        else $error("masked write changed data");
    rd_mask_a: assert property ((en && p.dqm) ##1 en |=> !s_q.pipe[0].v)
        else $error("read mask not two clocks");
    wr_first_a: assert property (en && (cmd == CMD_WR) && !p.dqm |=> s_q.mem[$past(acc_idx)] == $past(p.dq))
        else $error("first write word lost");
    pre_off_a: assert property ((en && pre_hit && rl == 3'h3) ##1 en [*3] |-> !s_q.pipe[0].v)
        else $error("outputs on after precharge");
    pre_off_two_a: assert property ((en && pre_hit && rl == 3'h2) ##1 en [*2] |-> !s_q.pipe[0].v)
        else $error("outputs on after precharge at latency two");
    act_reg_a: assert property (en && (cmd == CMD_ACT) |=> s_q.open[$past(s_q.p2.ba)])
        else $error("activate not registered");
    ap_close_a: assert property (acc_go && left_nxt == 3'h0 && ap_now |=> !s_q.open[$past(acc_ba)])
        else $error("auto precharge missed");

    rd_burst_c: cover property (s_q.pipe[0].v ##1 s_q.pipe[0].v);
    sref_c: cover property (s_q.pm == PM_SREF);
    init_c: cover property ($rose(s_q.init_done));
    lapse_c: cover property ($rose(s_q.expired));
endmodule

// ===== tb/sdct_ctrl_model.sv
// Purpose: Controller model that drives the SDRAM command, mask and data pins.
// Assumes: Pins change by non-blocking assignment just after mclk_i rises.
// Notes:   Gaps are whole 10 ns clocks, rounded up from the slowest grade.
`timescale 1ns/100ps
module sdct_ctrl_model
    import sdct_pkg::*;
(
    input  wire logic mclk_i,
    output sdct_pin_s pin_o,
    output logic      wdrv_o
);
    localparam int T_RCD = 2;
    localparam int T_RP  = 2;
    localparam int T_RFC = 7;
    localparam int T_XSR = 8;
    localparam int T_MRD = 2;

    initial
    begin
        pin_o  = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
        wdrv_o = 1'b0;
    end

    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [AW-1:0] a,
                         input logic [DW-1:0] d, input logic m, input logic w);
        @(posedge mclk_i);
        {pin_o.cs_n, pin_o.ras_n, pin_o.cas_n, pin_o.we_n} <= c;
        pin_o.ba   <= b;
        pin_o.addr <= a;
        // A released data bus toggles so a stale word is never mistaken for data.
        pin_o.dq   <= w ? d : ~pin_o.dq;
        pin_o.dqm  <= m;
        wdrv_o     <= w;
    endtask

    task automatic nop(input int n);
        repeat (n) issue(4'h7, 2'h0, '0, '0, 1'b0, 1'b0);
    endtask

    task automatic set_cke(input logic v);
        pin_o.cke <= v;
    endtask

    task automatic refresh();
        issue(CMD_REF, 2'h0, '0, '0, 1'b0, 1'b0);
        nop(T_RFC);
    endtask

    task automatic power_up(input int n);
        pin_o.cke <= 1'b1;
        nop(n);
        refresh();
        refresh();
    endtask

    task automatic activate(input logic [1:0] b);
        issue(CMD_ACT, b, '0, '0, 1'b0, 1'b0);
        nop(T_RCD);
    endtask

    task automatic load_mode(input logic [AW-1:0] op);
        issue(CMD_LMR, 2'h0, op, '0, 1'b0, 1'b0);
        nop(T_MRD);
    endtask

    task automatic precharge(input logic [1:0] b);
        issue(CMD_PRE, b, '0, '0, 1'b0, 1'b0);
        nop(T_RP);
    endtask

    task automatic sref_exit();
        pin_o.cke <= 1'b1;
        nop(T_XSR);
    endtask
endmodule

// ===== tb/sdct_core_tb.sv
// Purpose: Self-checking bench for the SDRAM device core.
// Assumes: Mode 0x022 gives read latency 2 and bursts of 4.
// Notes:   Data pins are logged each falling edge, index 0 after the command edge.
`timescale 1ns/100ps
module sdct_core_tb
    import sdct_pkg::*;
;
    localparam int INIT_P = 20;
    logic          mclk_i;
    logic          arst_n_i;
    sdct_pin_s     pin;
    logic          wdrv;
    logic [DW-1:0] dq_w;
    logic [DW-1:0] dq_o;
    logic          dq_oe_o;
    logic [3:0]    reg_addr_i;
    logic [31:0]   reg_wdata_i;
    logic          reg_wr_i;
    logic          reg_rd_i;
    logic [31:0]   reg_rdata_o;
    logic [31:0]   d;
    logic [DW:0]   obs[$];
    int            mismatches;
    int            total_checks;

    assign dq_w = wdrv ? pin.dq : (dq_oe_o ? dq_o : ~pin.dq);

    sdct_ctrl_model u_sdct_ctrl_model (.mclk_i(mclk_i), .pin_o(pin), .wdrv_o(wdrv));

    sdct_core #(.INIT_CYC_P(INIT_P), .REF_CYC_P(200), .REF_AT_CYC_P(100)) u_sdct_core (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .cs_n_i(pin.cs_n), .ras_n_i(pin.ras_n),
        .cas_n_i(pin.cas_n), .we_n_i(pin.we_n), .cke_i(pin.cke), .dqm_i(pin.dqm),
        .ba_i(pin.ba), .addr_i(pin.addr), .dq_i(dq_w), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

    always #5 mclk_i = ~mclk_i;

    always @(negedge mclk_i)
        obs.push_back({dq_oe_o, dq_o});

    // ----------------------------------------
    // Checking and register access
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic oseq(input logic [DW:0] e [6]);
        for (int i = 0; i < 6; i++)
            if (e[i][DW])
                chk(32'(obs[i+4]), 32'(e[i]));
            else
                chk(32'(obs[i+4][DW]), 32'h0);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        // The answer stands for the cycle after the strobe edge; take it at the edge that ends it.
        @(posedge mclk_i);
        v = reg_rdata_o;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] v;
        reg_rd(a, v);
        chk(v & m, e);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        mclk_i = 1'b0;
        arst_n_i = 1'b0;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (6) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rchk(REG_MODE, 32'(MODE_RST), 32'hfff);
        rchk(REG_STAT, 32'h300, 32'h701);
        reg_wr(4'hc, 32'hffffffff);
        rchk(4'hc, 32'h0, 32'hffffffff);
        reg_wr(REG_CFG, 32'h1);
        rchk(REG_CFG, 32'h1, 32'h1);
        reg_wr(REG_CFG, 32'h0);
        u_sdct_ctrl_model.power_up(INIT_P + 4);
        rchk(REG_STAT, 32'h1, 32'h1);
        u_sdct_ctrl_model.load_mode(12'h022);
        rchk(REG_MODE, 32'h022, 32'hfff);
        u_sdct_ctrl_model.activate(2'h0);
        rchk(REG_STAT, 32'h210, 32'h7f0);
        // Second WRITE cuts the first burst short; its last beat is masked.
        u_sdct_ctrl_model.issue(CMD_WR, 2'h0, 12'h000, 8'ha1, 1'b0, 1'b1);
        u_sdct_ctrl_model.issue(4'h7, 2'h0, '0, 8'hb2, 1'b0, 1'b1);
        u_sdct_ctrl_model.issue(CMD_WR, 2'h0, 12'h002, 8'hc3, 1'b0, 1'b1);
        u_sdct_ctrl_model.issue(4'h7, 2'h0, '0, 8'hd4, 1'b1, 1'b1);
        u_sdct_ctrl_model.issue(CMD_BST, 2'h0, '0, '0, 1'b1, 1'b0);
        u_sdct_ctrl_model.nop(2);
        u_sdct_ctrl_model.issue(CMD_RD, 2'h0, 12'h000, '0, 1'b0, 1'b0);
        obs.delete();
        u_sdct_ctrl_model.issue(CMD_RD, 2'h0, 12'h002, '0, 1'b0, 1'b0);
        u_sdct_ctrl_model.nop(10);
        oseq('{9'h1a1, 9'h1c3, 9'h100, 9'h1a1, 9'h1b2, 9'h000});
        u_sdct_ctrl_model.issue(CMD_RD, 2'h0, 12'h000, '0, 1'b0, 1'b0);
        obs.delete();
        u_sdct_ctrl_model.issue(4'h7, 2'h0, '0, '0, 1'b1, 1'b0);
        u_sdct_ctrl_model.nop(10);
        oseq('{9'h1a1, 9'h000, 9'h1c3, 9'h100, 9'h000, 9'h000});
        u_sdct_ctrl_model.issue(CMD_RD, 2'h0, 12'h000, '0, 1'b0, 1'b0);
        obs.delete();
        u_sdct_ctrl_model.nop(1);
        u_sdct_ctrl_model.set_cke(1'b0);
        u_sdct_ctrl_model.nop(1);
        u_sdct_ctrl_model.set_cke(1'b1);
        u_sdct_ctrl_model.nop(10);
        oseq('{9'h1a1, 9'h1a1, 9'h1b2, 9'h1c3, 9'h100, 9'h000});
        u_sdct_ctrl_model.issue(CMD_RD, 2'h0, 12'h000, '0, 1'b0, 1'b0);
        obs.delete();
        u_sdct_ctrl_model.precharge(2'h0);
        u_sdct_ctrl_model.nop(8);
        oseq('{9'h1a1, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000});
        u_sdct_ctrl_model.activate(2'h1);
        u_sdct_ctrl_model.issue(CMD_RD, 2'h1, 12'h000, '0, 1'b0, 1'b0);
        u_sdct_ctrl_model.nop(8);
        rchk(REG_STAT, 32'h20, 32'hf0);
        u_sdct_ctrl_model.issue(CMD_RD, 2'h1, 12'h400, '0, 1'b0, 1'b0);
        u_sdct_ctrl_model.nop(8);
        rchk(REG_STAT, 32'h0, 32'hf0);
        u_sdct_ctrl_model.set_cke(1'b0);
        u_sdct_ctrl_model.nop(4);
        rchk(REG_STAT, 32'h4, 32'hc);
        u_sdct_ctrl_model.set_cke(1'b1);
        u_sdct_ctrl_model.nop(4);
        rchk(REG_STAT, 32'h0, 32'hc);
        u_sdct_ctrl_model.issue(CMD_REF, 2'h0, '0, '0, 1'b0, 1'b0);
        u_sdct_ctrl_model.set_cke(1'b0);
        u_sdct_ctrl_model.nop(4);
        rchk(REG_STAT, 32'h8, 32'hc);
        u_sdct_ctrl_model.sref_exit();
        rchk(REG_STAT, 32'h0, 32'hc);
        // Too few refreshes in a window must drop the ready flag.
        for (int i = 0; i < 300; i++)
        begin
            reg_rd(REG_STAT, d);
            if (d[1])
                break;
        end
        chk(d & 32'h3, 32'h2);
        reg_wr(REG_STAT, 32'h2);
        rchk(REG_STAT, 32'h0, 32'h3);
        u_sdct_ctrl_model.refresh();
        u_sdct_ctrl_model.refresh();
        rchk(REG_STAT, 32'h1, 32'h3);
        print_verdict();
    end

    initial
    begin
        repeat (6000) @(posedge mclk_i);
        mismatches++;
        print_verdict();
    end
endmodule
